// [rtl/spw_pkg.sv]
package spw_pkg;

   // ****************************************************************
   // Widths and register map
   // ****************************************************************
   localparam int SPW_DW = 16;
   localparam int SPW_AW = 4;
   localparam logic [3:0] SPW_A_CTRL = 4'h0;
   localparam logic [3:0] SPW_A_SP0 = 4'h1;
   localparam logic [3:0] SPW_A_SP1 = 4'h2;
   localparam logic [3:0] SPW_A_SP2 = 4'h3;
   localparam logic [3:0] SPW_A_PERIOD = 4'h4;
   localparam logic [3:0] SPW_A_DEAD = 4'h5;
   localparam logic [3:0] SPW_A_TRIG0 = 4'h6;
   localparam logic [3:0] SPW_A_TRIG1 = 4'h7;
   localparam logic [3:0] SPW_A_CONV = 4'h8;
   localparam logic [3:0] SPW_A_STATUS = 4'h9;
   localparam logic [3:0] SPW_A_CMP_U = 4'hA;
   localparam logic [3:0] SPW_A_CMP_V = 4'hB;
   localparam logic [3:0] SPW_A_CMP_W = 4'hC;

   // Field positions
   localparam int SPW_CTRL_MODE_LSB = 0;
   localparam int SPW_CTRL_OE_BIT = 2;
   localparam int SPW_ST_OUT_BIT = 0;
   localparam int SPW_ST_PEND_BIT = 1;
   localparam int SPW_ST_BUSY_LSB = 2;
   localparam int SPW_ST_MODE_LSB = 4;

   // ****************************************************************
   // Reset values and fixed figures
   // ****************************************************************
   localparam logic [15:0] SPW_RST_PERIOD = 16'h031F;
   localparam logic [15:0] SPW_RST_DEAD = 16'h0080;
   localparam logic [15:0] SPW_RST_TRIG = 16'h0020;
   localparam logic [7:0] SPW_RST_CONV = 8'h0C;
   localparam logic [7:0] SPW_CONV_32CLK = 8'h0C;
   localparam logic [7:0] SPW_CONV_CLKS = 8'h20;
   localparam int SPW_CNT_DIV = 2;
   localparam int SPW_CLK_MHZ = 125;
   localparam int SPW_CONV_TIME_NS = 2000;
   localparam int SPW_CONV_CYC_INT =
      (SPW_CONV_TIME_NS * SPW_CLK_MHZ + 999) / 1000;
   localparam logic [8:0] SPW_CONV_CYC = 9'(SPW_CONV_CYC_INT);

   // Angle: one full turn spans this many steps
   localparam int SPW_ANGLE_RES_INT = 10000;
   localparam logic [16:0] SPW_ANGLE_RES = 17'h02710;
   localparam logic [15:0] SPW_ANGLE_QUARTER = 16'h09C4;
   localparam logic [15:0] SPW_ANGLE_THIRD = 16'h0D05;
   localparam logic [15:0] SPW_ANGLE_TWO_THIRD = 16'h1A0B;
   localparam int SPW_SINE_STEPS = 64;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      SPW_DIRECT = 2'b00,
      SPW_DQ = 2'b01,
      SPW_LOCK = 2'b10
   } spw_mode_e;

   typedef struct packed {
      logic [15:0] period;
      logic [15:0] dead;
      logic [15:0] trig0;
      logic [15:0] trig1;
      spw_mode_e mode;
   } spw_cfg_s;

endpackage : spw_pkg

// [rtl/spw_dead_arm.sv]
`timescale 1ns/1ps
module spw_dead_arm
   import spw_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Count clock enable and raw carrier comparison
   input wire logic tick_i,
   input wire logic raw_i,
   input wire logic [15:0] dead_i,
   // Arm drives
   output logic hi_o,
   output logic lo_o
);

   logic raw_d_r;
   logic [15:0] since_r;
   logic changed;
   logic [15:0] since_eff;
   logic [15:0] since_nxt;

   // Count clocks since the last edge of the raw comparison
   assign changed = raw_i != raw_d_r;
   assign since_eff = changed ? 16'h0000 : since_r;
   assign since_nxt = (since_eff == 16'hFFFF) ? since_eff : since_eff + 16'h0001;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         raw_d_r <= 1'b0;
         since_r <= 16'h0000;
         hi_o <= 1'b0;
         lo_o <= 1'b0;
      end else if (tick_i) begin
         raw_d_r <= raw_i;
         since_r <= since_nxt;
         // Upper arm loses the first dead-time counts of each pulse
         hi_o <= raw_i && (since_eff >= dead_i);
         // Lower level stretches past the pulse; lower arm is active low
         lo_o <= raw_i || (since_eff < dead_i);
      end
   end

endmodule : spw_dead_arm

// [rtl/spw_six_phase.sv]
`timescale 1ns/1ps
module spw_six_phase
   import spw_pkg::*;
(
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_I,
   // Register port
   input wire logic [SPW_AW-1:0] ADDR_I,
   input wire logic [SPW_DW-1:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [SPW_DW-1:0] RDATA_O,
   // Phase pins: [2:0] upper U,V,W, [5:3] lower U,V,W
   output logic [5:0] PHASE_O,
   output logic [5:0] PHASE_OE_N_O,
   // Carrier and converter events
   output logic CARRIER_VALLEY_O,
   output logic ADC0_TRIG_O,
   output logic ADC1_TRIG_O,
   output logic [1:0] ADC_BUSY_O,
   output logic [1:0] ADC_DONE_O
);

   // ****************************************************************
   // Functions
   // ****************************************************************
   // Quarter-wave sine, 16 steps per quarter, scaled by 256
   function automatic logic signed [9:0] sine_q(input logic [4:0] k);
      logic signed [9:0] v;
      v = 10'sh000;
      case (k)
         5'h00: v = 10'sh000;
         5'h01: v = 10'sh019;
         5'h02: v = 10'sh032;
         5'h03: v = 10'sh04A;
         5'h04: v = 10'sh062;
         5'h05: v = 10'sh079;
         5'h06: v = 10'sh08E;
         5'h07: v = 10'sh0A2;
         5'h08: v = 10'sh0B5;
         5'h09: v = 10'sh0C6;
         5'h0A: v = 10'sh0D5;
         5'h0B: v = 10'sh0E2;
         5'h0C: v = 10'sh0ED;
         5'h0D: v = 10'sh0F5;
         5'h0E: v = 10'sh0FB;
         5'h0F: v = 10'sh0FE;
         default: v = 10'sh100;
      endcase
      return v;
   endfunction : sine_q

   // Folds an angle sum back into one turn
   function automatic logic [15:0] wrap_ang(input logic [16:0] a);
      return (a >= SPW_ANGLE_RES) ? 16'(a - SPW_ANGLE_RES) : a[15:0];
   endfunction : wrap_ang

   function automatic logic signed [9:0] sine(input logic [15:0] ang);
      logic [5:0] ix;
      logic [4:0] k;
      logic signed [9:0] m;
      ix = 6'((int'(ang) * SPW_SINE_STEPS) / SPW_ANGLE_RES_INT);
      k = {1'b0, ix[3:0]};
      m = ix[4] ? sine_q(5'h10 - k) : sine_q(k);
      return ix[5] ? -m : m;
   endfunction : sine

   // Phase voltage from d and q at a given electrical angle
   function automatic logic signed [18:0] dq_volt(
      input logic signed [15:0] d,
      input logic signed [15:0] q,
      input logic [15:0] ang);
      logic signed [9:0] s;
      logic signed [9:0] c;
      logic signed [26:0] acc;
      s = sine(ang);
      c = sine(wrap_ang({1'b0, ang} + {1'b0, SPW_ANGLE_QUARTER}));
      acc = d * c - q * s;
      return 19'(acc >>> 8);
   endfunction : dq_volt

   // Turns a requested on-width into a compare, kept inside the carrier
   function automatic logic [16:0] width_to_cmp(
      input logic signed [18:0] w,
      input logic [16:0] p1);
      logic signed [19:0] c;
      c = $signed({3'b000, p1}) - 20'(w);
      if (c < 0)
         return 17'h00000;
      else if (c > $signed({3'b000, p1}))
         return p1;
      else
         return c[16:0];
   endfunction : width_to_cmp

   // Conversion length; only the 32-clock setting is defined
   function automatic logic [8:0] conv_cycles(input logic [7:0] ctl);
      return (ctl == SPW_CONV_32CLK) ? SPW_CONV_CYC : SPW_CONV_CYC;
   endfunction : conv_cycles

   // ****************************************************************
   // Registers
   // ****************************************************************
   spw_cfg_s stg_r;
   spw_cfg_s cfg_r;
   logic signed [15:0] sp_r [3];
   logic [16:0] cmp_r [3];
   logic [7:0] conv_ctl_r;
   logic out_en_r;
   logic pending_r;
   logic div_r;
   logic [16:0] cnt_r;
   logic up_r;
   logic armed_r;
   logic [15:0] trig_cnt_r;
   logic [8:0] busy_cnt_r [2];
   logic [5:0] raw_r;

   // ****************************************************************
   // Register port decode
   // ****************************************************************
   logic wr_ctrl;
   logic wr_stage_ok;
   logic wr_u;
   logic [15:0] status_w;
   logic [15:0] rdata_nxt;

   // Staged registers refuse writes until the pending commit lands
   assign wr_stage_ok = WR_I && !pending_r;
   assign wr_ctrl = WR_I && (ADDR_I == SPW_A_CTRL);
   assign wr_u = wr_stage_ok && (ADDR_I == SPW_A_SP0);

   assign status_w = {10'h000, cfg_r.mode,
      busy_cnt_r[1] != 9'h000, busy_cnt_r[0] != 9'h000,
      pending_r, out_en_r};

   assign rdata_nxt =
      !RD_I ? 16'h0000 :
      (ADDR_I == SPW_A_CTRL) ? {13'h0000, out_en_r, stg_r.mode} :
      (ADDR_I == SPW_A_SP0) ? sp_r[0] :
      (ADDR_I == SPW_A_SP1) ? sp_r[1] :
      (ADDR_I == SPW_A_SP2) ? sp_r[2] :
      (ADDR_I == SPW_A_PERIOD) ? stg_r.period :
      (ADDR_I == SPW_A_DEAD) ? stg_r.dead :
      (ADDR_I == SPW_A_TRIG0) ? stg_r.trig0 :
      (ADDR_I == SPW_A_TRIG1) ? stg_r.trig1 :
      (ADDR_I == SPW_A_CONV) ? {8'h00, conv_ctl_r} :
      (ADDR_I == SPW_A_STATUS) ? status_w :
      (ADDR_I == SPW_A_CMP_U) ? cmp_r[0][15:0] :
      (ADDR_I == SPW_A_CMP_V) ? cmp_r[1][15:0] :
      (ADDR_I == SPW_A_CMP_W) ? cmp_r[2][15:0] :
      16'h0000;

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I)
         RDATA_O <= 16'h0000;
      else
         RDATA_O <= rdata_nxt;
   end

   // Output enable acts at once; it is not a staged register
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I)
         out_en_r <= 1'b0;
      else if (wr_ctrl)
         out_en_r <= WDATA_I[SPW_CTRL_OE_BIT];
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         stg_r <= '{SPW_RST_PERIOD, SPW_RST_DEAD, SPW_RST_TRIG,
            SPW_RST_TRIG, SPW_DIRECT};
         conv_ctl_r <= SPW_RST_CONV;
         for (int i = 0; i < 3; i++)
            sp_r[i] <= 16'sh0000;
      end else if (wr_stage_ok) begin
         case (ADDR_I)
            SPW_A_CTRL: stg_r.mode <= spw_mode_e'(WDATA_I[1:0]);
            SPW_A_SP0: sp_r[0] <= WDATA_I;
            SPW_A_SP1: sp_r[1] <= WDATA_I;
            SPW_A_SP2: sp_r[2] <= WDATA_I;
            SPW_A_PERIOD: stg_r.period <= WDATA_I;
            SPW_A_DEAD: stg_r.dead <= WDATA_I;
            SPW_A_TRIG0: stg_r.trig0 <= WDATA_I;
            SPW_A_TRIG1: stg_r.trig1 <= WDATA_I;
            SPW_A_CONV: conv_ctl_r <= WDATA_I[7:0];
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // Count clock and carrier timer
   // ****************************************************************
   logic tick;
   logic [16:0] p1_cur;
   logic valley_now;
   logic commit;

   assign tick = div_r;
   assign p1_cur = {1'b0, cfg_r.period} + 17'h00001;
   // Valley is the count falling to zero; new settings load on that edge
   assign valley_now = tick && !up_r && (cnt_r == 17'h00001);
   assign commit = valley_now && pending_r;

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I)
         div_r <= 1'b0;
      else
         div_r <= ~div_r;
   end

   // Counts 1..P+1 upward then P..0 downward: 2*(P+1) counts per period
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cnt_r <= 17'h00000;
         up_r <= 1'b0;
      end else if (tick) begin
         if (up_r && (cnt_r >= p1_cur)) begin
            cnt_r <= p1_cur - 17'h00001;
            up_r <= 1'b0;
         end else if (!up_r && (cnt_r == 17'h00000)) begin
            cnt_r <= 17'h00001;
            up_r <= 1'b1;
         end else if (up_r) begin
            cnt_r <= cnt_r + 17'h00001;
         end else begin
            cnt_r <= cnt_r - 17'h00001;
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I)
         CARRIER_VALLEY_O <= 1'b0;
      else
         CARRIER_VALLEY_O <= valley_now;
   end

   // ****************************************************************
   // Phase compare selection and commit
   // ****************************************************************
   logic [16:0] p1_stg;
   logic signed [18:0] half_w;
   logic [15:0] ang_w [3];
   logic [16:0] cmp_nxt [3];

   assign p1_stg = {1'b0, stg_r.period} + 17'h00001;
   assign half_w = $signed({3'b000, p1_stg[16:1]});
   // Phase angles: U at theta, V 120 degrees behind, W 240 behind
   assign ang_w[0] = wrap_ang({1'b0, sp_r[2]});
   assign ang_w[1] = wrap_ang({1'b0, ang_w[0]} + {1'b0, SPW_ANGLE_TWO_THIRD});
   assign ang_w[2] = wrap_ang({1'b0, ang_w[0]} + {1'b0, SPW_ANGLE_THIRD});

   for (genvar g = 0; g < 3; g++) begin : g_cmp
      logic [16:0] direct_cmp;
      logic [16:0] dq_cmp;
      assign direct_cmp = width_to_cmp(19'(sp_r[g]), p1_stg);
      assign dq_cmp = width_to_cmp(half_w + dq_volt(sp_r[0], sp_r[1],
         ang_w[g]), p1_stg);
      assign cmp_nxt[g] =
         (stg_r.mode == SPW_DIRECT) ? direct_cmp :
         (stg_r.mode == SPW_DQ) ? dq_cmp :
         cmp_r[g];
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cfg_r <= '{SPW_RST_PERIOD, SPW_RST_DEAD, SPW_RST_TRIG,
            SPW_RST_TRIG, SPW_DIRECT};
         for (int i = 0; i < 3; i++)
            cmp_r[i] <= {1'b0, SPW_RST_PERIOD} + 17'h00001;
      end else if (commit) begin
         cfg_r <= stg_r;
         for (int i = 0; i < 3; i++)
            cmp_r[i] <= cmp_nxt[i];
      end
   end

   // A write during the commit edge is refused, so set and clear never meet
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I)
         pending_r <= 1'b0;
      else if (wr_u)
         pending_r <= 1'b1;
      else if (commit)
         pending_r <= 1'b0;
   end

   // ****************************************************************
   // Raw comparison and dead-time arms
   // ****************************************************************
   logic [2:0] raw_w;
   logic [2:0] arm_hi;
   logic [2:0] arm_lo;

   for (genvar g = 0; g < 3; g++) begin : g_arm
      // Symmetric about the peak: high for (P+1-C)*2 counts
      assign raw_w[g] = up_r ? (cnt_r > cmp_r[g]) : (cnt_r >= cmp_r[g]);

      spw_dead_arm u_arm (
         .clk_i(CLK_I),
         .rst_i(RST_I),
         .tick_i(tick),
         .raw_i(raw_w[g]),
         .dead_i(cfg_r.dead),
         .hi_o(arm_hi[g]),
         .lo_o(arm_lo[g])
      );
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         PHASE_O <= 6'h00;
         PHASE_OE_N_O <= 6'h3F;
      end else begin
         PHASE_O <= {arm_lo, arm_hi};
         PHASE_OE_N_O <= {6{~out_en_r}};
      end
   end

   // ****************************************************************
   // Converter trigger timer
   // ****************************************************************
   logic [15:0] trig_cnt_nxt;
   logic trig_step;
   logic [1:0] fire;

   // Runs on the carrier count clock, restarting at every valley
   assign trig_step = valley_now || (tick && armed_r && trig_cnt_r != 16'hFFFF);
   assign trig_cnt_nxt = valley_now ? 16'h0000 : trig_cnt_r + 16'h0001;
   assign fire[0] = trig_step && (trig_cnt_nxt == cfg_r.trig0);
   assign fire[1] = trig_step && (trig_cnt_nxt == cfg_r.trig1);

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         trig_cnt_r <= 16'h0000;
         armed_r <= 1'b0;
      end else if (trig_step) begin
         trig_cnt_r <= trig_cnt_nxt;
         armed_r <= 1'b1;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ADC0_TRIG_O <= 1'b0;
         ADC1_TRIG_O <= 1'b0;
      end else begin
         ADC0_TRIG_O <= fire[0];
         ADC1_TRIG_O <= fire[1];
      end
   end

   // ****************************************************************
   // Conversion timing
   // ****************************************************************
   // A trigger that arrives while busy is dropped, as the converter would
   for (genvar n = 0; n < 2; n++) begin : g_conv
      always_ff @(posedge CLK_I or posedge RST_I) begin
         if (RST_I) begin
            busy_cnt_r[n] <= 9'h000;
            ADC_BUSY_O[n] <= 1'b0;
            ADC_DONE_O[n] <= 1'b0;
         end else begin
            if (fire[n] && busy_cnt_r[n] == 9'h000) begin
               busy_cnt_r[n] <= conv_cycles(conv_ctl_r);
               ADC_BUSY_O[n] <= 1'b1;
            end else if (busy_cnt_r[n] != 9'h000) begin
               busy_cnt_r[n] <= busy_cnt_r[n] - 9'h001;
               ADC_BUSY_O[n] <= busy_cnt_r[n] != 9'h001;
            end
            ADC_DONE_O[n] <= busy_cnt_r[n] == 9'h001;
         end
      end
   end

endmodule : spw_six_phase

// [verification/spw_six_phase_assertions.sv]
`timescale 1ns/1ps
module spw_six_phase_chk
   import spw_pkg::*;
(
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_I,
   // Register port
   input wire logic RD_I,
   input wire logic [SPW_DW-1:0] RDATA_O,
   // Pins and events
   input wire logic [5:0] PHASE_O,
   input wire logic [5:0] PHASE_OE_N_O,
   input wire logic CARRIER_VALLEY_O,
   input wire logic ADC0_TRIG_O,
   input wire logic ADC1_TRIG_O,
   input wire logic [1:0] ADC_BUSY_O,
   input wire logic [1:0] ADC_DONE_O
);
   // ****
   // Helpers
   // ****
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   logic [8:0] busy_cnt_r;
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) busy_cnt_r <= 9'h000;
      else if (ADC_BUSY_O[0]) busy_cnt_r <= busy_cnt_r + 9'h001;
      else busy_cnt_r <= 9'h000;
   end
   sequence s_busy_end;
      $fell(ADC_BUSY_O[0]);
   endsequence
   // ****
   // Properties
   // ****
   property p_busy_len;
      s_busy_end |-> busy_cnt_r == SPW_CONV_CYC;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("conversion busy time wrong");
   property p_done;
      s_busy_end |-> ##[0:1] ADC_DONE_O[0];
   endproperty
   a_done: assert property (p_done)
      else $error("no done pulse after conversion");
   property p_busy_cause;
      $rose(ADC_BUSY_O[0]) |-> ADC0_TRIG_O || $past(ADC0_TRIG_O);
   endproperty
   a_busy_cause: assert property (p_busy_cause)
      else $error("conversion started without trigger");
   property p_valley;
      CARRIER_VALLEY_O |=> !CARRIER_VALLEY_O;
   endproperty
   a_valley: assert property (p_valley)
      else $error("valley pulse too long");
   property p_trig;
      ADC0_TRIG_O |=> !ADC0_TRIG_O;
   endproperty
   a_trig: assert property (p_trig)
      else $error("trigger pulse too long");
   property p_oe;
      PHASE_OE_N_O == 6'h00 || PHASE_OE_N_O == 6'h3F;
   endproperty
   a_oe: assert property (p_oe)
      else $error("pin enables differ");
   property p_rd_idle;
      !$past(RD_I) |-> RDATA_O == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside read cycle");
   property p_overlap;
      (PHASE_O[2:0] & ~PHASE_O[5:3]) == 3'h0;
   endproperty
   a_overlap: assert property (p_overlap)
      else $error("upper and lower arm both on");
   property p_tick;
      $changed(PHASE_O) |=> $stable(PHASE_O);
   endproperty
   a_tick: assert property (p_tick)
      else $error("pins changed between count ticks");
endmodule : spw_six_phase_chk

bind spw_six_phase spw_six_phase_chk chk_i (.CLK_I, .RST_I, .RD_I,
   .RDATA_O, .PHASE_O, .PHASE_OE_N_O, .CARRIER_VALLEY_O, .ADC0_TRIG_O,
   .ADC1_TRIG_O, .ADC_BUSY_O, .ADC_DONE_O);

// [verification/spw_gate_stage.sv]
`timescale 1ns/1ps
module spw_gate_stage (
   // Clock
   input wire logic clk_i,
   // Gate inputs from the generator
   input wire logic [5:0] gate_i,
   input wire logic [5:0] oe_n_i,
   // Last high run of each gate input, in clocks
   output logic [15:0] run_o [6]
);
   // Driver inputs have pull-downs, so a floated pin reads low
   logic [5:0] lvl;
   logic [15:0] cnt [6];
   assign lvl = gate_i & ~oe_n_i;
   initial begin
      for (int i = 0; i < 6; i++) begin
         cnt[i] = 16'h0000;
         run_o[i] = 16'h0000;
      end
   end
   always @(posedge clk_i) begin
      for (int i = 0; i < 6; i++) begin
         if (lvl[i] === 1'b1) cnt[i] <= cnt[i] + 16'h0001;
         else begin
            if (cnt[i] != 16'h0000) run_o[i] <= cnt[i];
            cnt[i] <= 16'h0000;
         end
      end
   end
endmodule : spw_gate_stage

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
   import spw_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [15:0] rdata, v;
   logic [5:0] phase, oe_n;
   logic valley, trig0, trig1;
   logic [1:0] busy, done;
   logic [15:0] run [6];
   int fails = 0;
   int tests_run = 0;
   int cyc = 0;
   int n;
   int sp [3] = '{40, 20, 70};

   spw_six_phase spw_six_phase_i (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata),
      .PHASE_O(phase), .PHASE_OE_N_O(oe_n), .CARRIER_VALLEY_O(valley),
      .ADC0_TRIG_O(trig0), .ADC1_TRIG_O(trig1), .ADC_BUSY_O(busy),
      .ADC_DONE_O(done));
   spw_gate_stage spw_gate_stage_i (.clk_i(clk), .gate_i(phase),
      .oe_n_i(oe_n), .run_o(run));

   always #4 clk = ~clk;
   // Ceiling well above the roughly 13000 cycles the run needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails++;
         conclude();
      end
   end

   // ****
   // Tasks
   // ****
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 d = rdata;
   endtask : rd
   task automatic wv(output int c);
      c = 0;
      do begin
         @(posedge clk);
         #1 c++;
      end while (valley !== 1'b1 && c < 5000);
   endtask : wv
   task automatic wtrig(output int c);
      c = 0;
      do begin
         @(posedge clk);
         #1 c++;
      end while (trig0 !== 1'b1 && c < 5000);
   endtask : wtrig
   // Staged writes go first, the first setpoint last since it arms commit
   task cmt(input logic [15:0] ctl, s0, s1, s2);
      wr(SPW_A_CTRL, ctl);
      wr(SPW_A_SP1, s1);
      wr(SPW_A_SP2, s2);
      wr(SPW_A_SP0, s0);
      wv(n);
      wv(n);
   endtask : cmt
   task conclude;
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude

   // ****
   // Sequence
   // ****
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(SPW_A_PERIOD, v); chk(v, 16'h031F);
      rd(SPW_A_DEAD, v); chk(v, 16'h0080);
      rd(SPW_A_TRIG1, v); chk(v, 16'h0020);
      rd(SPW_A_CONV, v); chk(v, 16'h000C);
      rd(SPW_A_CMP_U, v); chk(v, 16'h0320);
      rd(SPW_A_STATUS, v); chk(v, 16'h0000);
      rd(4'hF, v); chk(v, 16'h0000);
      chk({10'h000, oe_n}, 16'h003F);
      wv(n);
      wv(n); chk(16'(n), 16'h0C80);
      wtrig(n); chk(16'(n), 16'h0040);
      chk({15'h0000, trig1}, 16'h0001);
      chk({14'h0000, busy}, 16'h0003);
      wr(SPW_A_PERIOD, 16'h0063);
      wr(SPW_A_DEAD, 16'h0008);
      wr(SPW_A_TRIG0, 16'h000A);
      wr(SPW_A_TRIG1, 16'h000A);
      wr(SPW_A_CTRL, 16'h0004);
      wr(SPW_A_SP1, 16'h0014);
      wr(SPW_A_SP2, 16'h0046);
      wr(SPW_A_SP0, 16'h0028);
      wr(SPW_A_DEAD, 16'h0005);
      rd(SPW_A_STATUS, v); chk(v & 16'h0003, 16'h0003);
      chk({10'h000, oe_n}, 16'h0000);
      wv(n);
      rd(SPW_A_DEAD, v); chk(v, 16'h0008);
      wv(n);
      wv(n); chk(16'(n), 16'h0190);
      wtrig(n); chk(16'(n), 16'h0014);
      for (int i = 0; i < 3; i++) begin
         chk(run[i], 16'((2 * sp[i] - 8) * 2));
         chk(run[i + 3], 16'((2 * sp[i] + 8) * 2));
      end
      rd(SPW_A_CMP_V, v); chk(v, 16'h0050);
      rd(SPW_A_CMP_W, v); chk(v, 16'h001E);
      cmt(16'h0006, 16'h000A, 16'h000A, 16'h000A);
      rd(SPW_A_CMP_U, v); chk(v, 16'h003C);
      rd(SPW_A_STATUS, v); chk(v & 16'h0030, 16'h0020);
      cmt(16'h0005, 16'h0000, 16'h0000, 16'h09C4);
      rd(SPW_A_CMP_U, v); chk(v, 16'h0032);
      rd(SPW_A_CMP_W, v); chk(v, 16'h0032);
      rd(SPW_A_STATUS, v); chk(v & 16'h0030, 16'h0010);
      cmt(16'h0004, 16'h0384, 16'hFFFB, 16'h0032);
      rd(SPW_A_CMP_U, v); chk(v, 16'h0000);
      rd(SPW_A_CMP_V, v); chk(v, 16'h0064);
      wr(SPW_A_CTRL, 16'h0000);
      rd(SPW_A_STATUS, v); chk(v & 16'h0001, 16'h0000);
      chk({10'h000, oe_n}, 16'h003F);
      conclude();
   end
endmodule : testbench
